// ===== logic/prl_pkg.sv
// pin remap lock control: shared register map, field layout and reset values
// assumes a 32-bit ahb-lite slave port and 26 remappable pins
package prl_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int PRL_NPINS = 26;
  localparam int PRL_SEL_W = 5;
  localparam int PRL_STAT_W = 3;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PRL_OFS_OSC_CTRL = 8'h00;
  localparam logic [7:0] PRL_OFS_IRQ1_MAP = 8'h04;
  localparam logic [7:0] PRL_OFS_ANA_LOW = 8'h08;
  localparam logic [7:0] PRL_OFS_ANA_HIGH = 8'h0C;
  localparam logic [7:0] PRL_OFS_STATUS = 8'h10;
  localparam logic [7:0] PRL_OFS_MASK = 8'h14;
  localparam logic [7:0] PRL_OFS_PIN_DIR = 8'h18;
  localparam logic [7:0] PRL_OFS_PIN_OUT = 8'h1C;
  localparam logic [7:0] PRL_OFS_PIN_READ = 8'h20;

  // ----------------------------------------------------------------
  // fields, keys and reset values
  // ----------------------------------------------------------------
  localparam int PRL_LOCK_BIT = 6;
  localparam int PRL_SEL_LSB = 8;
  localparam logic [7:0] PRL_KEY_FIRST = 8'h46;
  localparam logic [7:0] PRL_KEY_SECOND = 8'h57;
  localparam logic [4:0] PRL_SEL_RST = 5'h1F;
  localparam logic [4:0] PRL_SEL_MAX = 5'h19;
  localparam logic [25:0] PRL_ANA_RST = 26'h0000000;
  localparam logic [25:0] PRL_DIR_RST = 26'h3FFFFFF;
  localparam logic [25:0] PRL_OUT_RST = 26'h0000000;
  localparam logic [2:0] PRL_MASK_RST = 3'h0;
  localparam logic [2:0] PRL_HSIZE_WORD = 3'h2;

  // status bit positions
  localparam int PRL_ST_MISMATCH = 0;
  localparam int PRL_ST_DISCARD = 1;
  localparam int PRL_ST_LOCKCHG = 2;

  typedef enum logic [1:0] {
    PRL_KEY_IDLE = 2'b00,
    PRL_KEY_ONE = 2'b01,
    PRL_KEY_OPEN = 2'b10
  } prl_key_t;

endpackage

// ===== logic/prl_map_cell.sv
// one map register with its shadow copy and continuous comparison
// assumes the owner gates writes by the lock and drives clr on a mismatch
`timescale 1ns/100ps
module prl_map_cell
#(
  parameter int W = 5,
  parameter logic [W-1:0] RST = '1
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clr,
  input wire logic we,
  input wire logic [W-1:0] wdata,
  input wire logic [W-1:0] upset,
  output logic [W-1:0] value,
  output logic mismatch
);

  logic [W-1:0] main_r;
  logic [W-1:0] shadow_r;

  // ----------------------------------------------------------------
  // storage; upset models a disturbed cell, shadow is never disturbed
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      main_r <= RST;
      shadow_r <= RST;
    end
    else if (clr)
    begin
      main_r <= RST;
      shadow_r <= RST;
    end
    else if (we)
    begin
      main_r <= wdata;
      shadow_r <= wdata;
    end
    else
    begin
      main_r <= main_r ^ upset;
    end
  end

  assign value = main_r;
  assign mismatch = (main_r != shadow_r);

  shadow_track_a: assert property (@(posedge hclk) disable iff (!hresetn)
    we && !clr |=> !mismatch && value == $past(wdata))
    else $error("map write not mirrored in shadow");

endmodule

// ===== logic/prl_remap_lock.sv
// pin remap lock control: lock key sequence, one-session fuse, shadow check,
// external interrupt 1 input map, analog pin defaults and pin drive
// assumes one ahb-lite master, single word transfers, pins synchronous to hclk
// What this block does
// - locked map writes are dropped and set the discard status bit
// - lock bit is bit 6 of oscillator control
// - key 0x46 then 0x57 then lock write
// - lock holds until software or a shadow mismatch changes it
// - shadow mismatch raises configuration mismatch reset
// - fuse set: set lock cannot be cleared by software, only by a shadow mismatch
// - fuse unprogrammed default is set
// - analog pins default, digital read returns zero
// - all converter configs one makes pin digital
// - output driver works even when analog
// - leftmost enabled pin function wins
// - five-bit field routes pin to interrupt one
// - map register unused bits read zero, field resets ones
`timescale 1ns/100ps
module prl_remap_lock
  import prl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic single_session_fuse,
  input wire logic [25:0] pin_in,
  input wire logic [4:0] upset_inject,
  output logic [25:0] pin_out,
  output logic [25:0] pin_oe,
  output logic external_irq_one,
  output logic map_write_lock,
  output logic cfg_mismatch_rst
);

  // ----------------------------------------------------------------
  // bus slave: one wait state on every word transfer
  // ----------------------------------------------------------------
  logic dp_r;
  logic wr_r;
  logic [7:0] addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  wire take = hsel && htrans[1] && hready && (hsize == PRL_HSIZE_WORD);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_r <= 1'b0;
      wr_r <= 1'b0;
      addr_r <= 8'h00;
      hreadyout_r <= 1'b1;
    end
    else
    begin
      dp_r <= take;
      hreadyout_r <= !take;
      if (take)
      begin
        wr_r <= hwrite;
        addr_r <= haddr[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire do_wr = dp_r && wr_r;
  wire do_rd = dp_r && !wr_r;
  wire wr_osc = do_wr && (addr_r == PRL_OFS_OSC_CTRL);
  wire wr_map = do_wr && (addr_r == PRL_OFS_IRQ1_MAP);
  wire wr_ana_lo = do_wr && (addr_r == PRL_OFS_ANA_LOW);
  wire wr_ana_hi = do_wr && (addr_r == PRL_OFS_ANA_HIGH);
  wire wr_mask = do_wr && (addr_r == PRL_OFS_MASK);
  wire wr_dir = do_wr && (addr_r == PRL_OFS_PIN_DIR);
  wire wr_out = do_wr && (addr_r == PRL_OFS_PIN_OUT);
  wire rd_stat = do_rd && (addr_r == PRL_OFS_STATUS);
  wire [7:0] wbyte = hwdata[7:0];

  // ----------------------------------------------------------------
  // fuse capture after reset release; unprogrammed reads as set
  // ----------------------------------------------------------------
  logic fuse_r;
  logic fuse_cap_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fuse_r <= 1'b1;
      fuse_cap_r <= 1'b0;
    end
    else if (!fuse_cap_r)
    begin
      fuse_r <= single_session_fuse;
      fuse_cap_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // key sequence and lock
  // ----------------------------------------------------------------
  prl_key_t key_r;
  prl_key_t key_nxt;
  logic lock_r;
  logic lock_nxt;
  logic mismatch;
  wire new_lock = hwdata[PRL_LOCK_BIT];
  wire key_open_wr = wr_osc && (key_r == PRL_KEY_OPEN);
  // a set lock under the one-session fuse refuses to clear
  wire clr_blocked = fuse_r && lock_r && !new_lock;

  always_comb
  begin
    key_nxt = key_r;
    if (mismatch)
      key_nxt = PRL_KEY_IDLE;
    else if (do_wr)
    begin
      // any other write in between breaks the sequence
      if (!wr_osc)
        key_nxt = PRL_KEY_IDLE;
      else
      begin
        case (key_r)
          PRL_KEY_IDLE: key_nxt = (wbyte == PRL_KEY_FIRST) ? PRL_KEY_ONE : PRL_KEY_IDLE;
          PRL_KEY_ONE: key_nxt = (wbyte == PRL_KEY_SECOND) ? PRL_KEY_OPEN :
                         (wbyte == PRL_KEY_FIRST) ? PRL_KEY_ONE : PRL_KEY_IDLE;
          PRL_KEY_OPEN: key_nxt = PRL_KEY_IDLE;
          default: key_nxt = PRL_KEY_IDLE;
        endcase
      end
    end
  end

  always_comb
  begin
    lock_nxt = lock_r;
    if (mismatch)
      lock_nxt = 1'b0;
    else if (key_open_wr && !clr_blocked)
      lock_nxt = new_lock;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      key_r <= PRL_KEY_IDLE;
      lock_r <= 1'b0;
    end
    else
    begin
      key_r <= key_nxt;
      lock_r <= lock_nxt;
    end
  end

  // ----------------------------------------------------------------
  // input map register for external interrupt 1
  // ----------------------------------------------------------------
  logic [4:0] sel;
  wire map_we = wr_map && !lock_r;
  wire discard_evt = wr_map && lock_r;

  prl_map_cell #(.W(PRL_SEL_W), .RST(PRL_SEL_RST)) u_irq1_map
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .clr(mismatch),
    .we(map_we),
    .wdata(hwdata[PRL_SEL_LSB +: PRL_SEL_W]),
    .upset(upset_inject),
    .value(sel),
    .mismatch(mismatch)
  );

  // ----------------------------------------------------------------
  // pin configuration and pin function priority
  // ----------------------------------------------------------------
  logic [25:0] ana_lo_r;
  logic [25:0] ana_hi_r;
  logic [25:0] dir_r;
  logic [25:0] out_r;
  logic [2:0] mask_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ana_lo_r <= PRL_ANA_RST;
      ana_hi_r <= PRL_ANA_RST;
      dir_r <= PRL_DIR_RST;
      out_r <= PRL_OUT_RST;
      mask_r <= PRL_MASK_RST;
    end
    else
    begin
      if (wr_ana_lo)
        ana_lo_r <= hwdata[25:0];
      if (wr_ana_hi)
        ana_hi_r <= hwdata[25:0];
      if (wr_dir)
        dir_r <= hwdata[25:0];
      if (wr_out)
        out_r <= hwdata[25:0];
      if (wr_mask)
        mask_r <= hwdata[2:0];
    end
  end

  // analog sits leftmost on every shared pin: the digital buffer only sees
  // the pin once both converters release it
  wire [25:0] digital_en = ana_lo_r & ana_hi_r;
  wire [25:0] pin_rd = pin_in & digital_en;
  // remapping does not override direction; software keeps dir at input
  wire sel_valid = (sel <= PRL_SEL_MAX);
  wire irq1_src = sel_valid ? pin_rd[sel] : 1'b0;

  // ----------------------------------------------------------------
  // status, mask and interrupt; a set wins over the read clear
  // ----------------------------------------------------------------
  logic [2:0] stat_r;
  wire lock_evt = (lock_nxt != lock_r) && !mismatch;
  wire [2:0] evt = {lock_evt, discard_evt, mismatch};
  wire [2:0] stat_nxt = (stat_r & ~{3{rd_stat}}) | evt;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [31:0] osc_rd = {24'h000000, 1'b0, lock_r, 6'h00};
  wire [31:0] map_rd = {16'h0000, 3'h0, sel, 8'h00};
  wire [31:0] rdata =
    (addr_r == PRL_OFS_OSC_CTRL) ? osc_rd :
    (addr_r == PRL_OFS_IRQ1_MAP) ? map_rd :
    (addr_r == PRL_OFS_ANA_LOW) ? {6'h00, ana_lo_r} :
    (addr_r == PRL_OFS_ANA_HIGH) ? {6'h00, ana_hi_r} :
    (addr_r == PRL_OFS_STATUS) ? {29'h00000000, stat_r} :
    (addr_r == PRL_OFS_MASK) ? {29'h00000000, mask_r} :
    (addr_r == PRL_OFS_PIN_DIR) ? {6'h00, dir_r} :
    (addr_r == PRL_OFS_PIN_OUT) ? {6'h00, out_r} :
    (addr_r == PRL_OFS_PIN_READ) ? {6'h00, pin_rd} : 32'h00000000;

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  logic irq_r;
  logic irq1_r;
  logic mm_r;
  logic [25:0] pin_oe_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stat_r <= 3'h0;
      hrdata_r <= 32'h00000000;
      irq_r <= 1'b0;
      irq1_r <= 1'b0;
      mm_r <= 1'b0;
      pin_oe_r <= 26'h0000000;
    end
    else
    begin
      stat_r <= stat_nxt;
      if (do_rd)
        hrdata_r <= rdata;
      irq_r <= |(stat_nxt & mask_r);
      irq1_r <= irq1_src;
      mm_r <= mismatch;
      pin_oe_r <= ~dir_r;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;
  assign irq = irq_r;
  assign pin_out = out_r;
  assign pin_oe = pin_oe_r;
  assign external_irq_one = irq1_r;
  assign map_write_lock = lock_r;
  assign cfg_mismatch_rst = mm_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  locked_drop_a: assert property (discard_evt && !mismatch |=> $stable(sel))
    else $error("locked map write changed the register");
  lock_key_a: assert property ($changed(lock_r) |->
    $past(key_r) == PRL_KEY_OPEN && $past(wr_osc) || $past(mismatch))
    else $error("lock changed without the key sequence");
  // key writes are never closer than two cycles: each write costs a wait state
  key_step_a: assert property (wr_osc && wbyte == PRL_KEY_FIRST && !mismatch
    && key_r == PRL_KEY_IDLE ##[2:3] wr_osc && wbyte == PRL_KEY_SECOND && !mismatch
    |=> key_r == PRL_KEY_OPEN)
    else $error("key sequence not opened");
  lock_bit_a: assert property (do_rd && addr_r == PRL_OFS_OSC_CTRL |=>
    hrdata[PRL_LOCK_BIT] == $past(lock_r) && hreadyout)
    else $error("lock bit read back wrong");
  lock_hold_a: assert property (!wr_osc && !mismatch |=> $stable(lock_r))
    else $error("lock changed by itself");
  fuse_block_a: assert property (fuse_r && lock_r && !mismatch |=> lock_r)
    else $error("lock cleared under single session fuse");
  mismatch_rst_a: assert property (mismatch |=> cfg_mismatch_rst && !lock_r
    && sel == PRL_SEL_RST ##1 !cfg_mismatch_rst)
    else $error("mismatch reset not raised or not restored");
  map_zero_a: assert property (do_rd && addr_r == PRL_OFS_IRQ1_MAP |=>
    hrdata[31:13] == 19'h00000 && hrdata[7:0] == 8'h00)
    else $error("unimplemented map bits not zero");
  analog_gate_a: assert property (sel_valid && !digital_en[sel] |=> !external_irq_one)
    else $error("analog pin reached the interrupt input");
  sel_ground_a: assert property (!sel_valid |=> !external_irq_one)
    else $error("reserved or ground select not grounded");
  drive_a: assert property (1'b1 |=> pin_oe == ~$past(dir_r))
    else $error("output enable does not follow direction");
  irq_level_a: assert property (1'b1 |=> irq == |(stat_r & $past(mask_r)))
    else $error("interrupt level mismatch");

  unlock_c: cover property (key_open_wr && !new_lock && lock_r);
  discard_c: cover property (discard_evt);
  mismatch_c: cover property (mismatch);
  irq_c: cover property ($rose(irq));

endmodule

// ===== tb/prl_remap_lock_tb.sv
// self-checking bench for the pin remap lock block
// assumes prl_pkg offsets and a single ahb-lite master driven here
`timescale 1ns/100ps
module tb
  import prl_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic x;} prl_row_t;
  logic hclk, hresetn, hsel, hwrite, single_session_fuse;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [25:0] pin_in, pin_out, pin_oe;
  logic [4:0] upset_inject;
  logic hreadyout, hresp, irq, external_irq_one, map_write_lock, cfg_mismatch_rst;
  int err_total, samples_checked, n;
  // x column: expected routed interrupt, x where it is not looked at
  prl_row_t rows [0:12] = '{
    '{PRL_OFS_ANA_LOW, 32'hFFFFFFFF, 32'h03FFFFFF, 1'bx},
    '{PRL_OFS_ANA_HIGH, 32'h02000021, 32'h02000021, 1'bx},
    '{PRL_OFS_PIN_READ, 32'hFFFFFFFF, 32'h02000021, 1'bx},
    '{PRL_OFS_IRQ1_MAP, 32'hFFFFE5FF, 32'h00000500, 1'b1},
    '{PRL_OFS_IRQ1_MAP, 32'h00001900, 32'h00001900, 1'b1},
    '{PRL_OFS_IRQ1_MAP, 32'h00001A00, 32'h00001A00, 1'b0},
    '{PRL_OFS_IRQ1_MAP, 32'h00001F00, 32'h00001F00, 1'b0},
    '{PRL_OFS_IRQ1_MAP, 32'h00000200, 32'h00000200, 1'b0},
    '{PRL_OFS_MASK, 32'h00000007, 32'h00000007, 1'bx},
    '{PRL_OFS_PIN_DIR, 32'h03FFFFFC, 32'h03FFFFFC, 1'bx},
    '{PRL_OFS_PIN_OUT, 32'h00000003, 32'h00000003, 1'bx},
    '{8'h40, 32'hFFFFFFFF, 32'h00000000, 1'bx},
    '{PRL_OFS_OSC_CTRL, 32'h00000040, 32'h00000000, 1'bx}};

  prl_remap_lock prl_remap_lock_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .irq(irq),
    .single_session_fuse(single_session_fuse),
    .pin_in(pin_in),
    .upset_inject(upset_inject),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .external_irq_one(external_irq_one),
    .map_write_lock(map_write_lock),
    .cfg_mismatch_rst(cfg_mismatch_rst)
  );

  initial hclk = 1'b0;
  always #5 hclk = ~hclk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // a stalled slave is cut off after 20 edges rather than hanging the run
  task automatic wait_rdy();
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    chk(32'(n < 20), 32'h1);
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= PRL_HSIZE_WORD;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic key(input logic [7:0] b);
    wr(PRL_OFS_OSC_CTRL, {24'h0, PRL_KEY_FIRST});
    wr(PRL_OFS_OSC_CTRL, {24'h0, PRL_KEY_SECOND});
    wr(PRL_OFS_OSC_CTRL, {24'h0, b});
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(32'({map_write_lock, irq, external_irq_one, pin_oe}), 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial
  begin
    #100000;
    err_total++;
    $display("ERROR %0t: watchdog expired", $time);
    stop_test();
  end

  initial
  begin
    {hresetn, hsel, hwrite, single_session_fuse} = 4'h0;
    {haddr, hwdata, htrans, hsize, upset_inject} = '0;
    pin_in = '1;
    err_total = 0;
    samples_checked = 0;
    do_reset();
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
      if (rows[i].x !== 1'bx)
        chk(32'(external_irq_one), 32'(rows[i].x));
    end
    done("table");
    chk(32'({hresp, pin_oe[2:0], pin_out[1:0]}), 32'h0F);
    key(8'h40);
    chk(32'({map_write_lock, irq}), 32'h3);
    rd(PRL_OFS_OSC_CTRL, 32'h40);
    rd(PRL_OFS_STATUS, 32'h4);
    chk(32'(irq), 32'h0);
    wr(PRL_OFS_IRQ1_MAP, 32'h1900);
    rd(PRL_OFS_IRQ1_MAP, 32'h0200);
    rd(PRL_OFS_STATUS, 32'h2);
    done("lock");
    // broken key sequences must leave the lock alone
    wr(PRL_OFS_OSC_CTRL, 32'h46);
    wr(PRL_OFS_OSC_CTRL, 32'h12);
    wr(PRL_OFS_OSC_CTRL, 32'h57);
    wr(PRL_OFS_OSC_CTRL, 32'h00);
    chk(32'(map_write_lock), 32'h1);
    key(8'h00);
    chk(32'(map_write_lock), 32'h0);
    wr(PRL_OFS_IRQ1_MAP, 32'h0700);
    wr(PRL_OFS_IRQ1_MAP, 32'h1900);
    rd(PRL_OFS_IRQ1_MAP, 32'h1900);
    chk(32'(map_write_lock), 32'h0);
    done("unlock");
    key(8'h40);
    rd(PRL_OFS_STATUS, 32'h4);
    upset_inject <= 5'h03;
    @(posedge hclk);
    upset_inject <= 5'h00;
    n = 0;
    while (cfg_mismatch_rst !== 1'b1 && n < 10)
    begin
      @(posedge hclk);
      n++;
    end
    chk(32'(cfg_mismatch_rst), 32'h1);
    repeat (3) @(posedge hclk);
    chk(32'(map_write_lock), 32'h0);
    rd(PRL_OFS_IRQ1_MAP, 32'h1F00);
    rd(PRL_OFS_STATUS, 32'h1);
    done("mismatch");
    single_session_fuse <= 1'b1;
    do_reset();
    rd(PRL_OFS_IRQ1_MAP, 32'h1F00);
    rd(PRL_OFS_ANA_LOW, 32'h0);
    rd(PRL_OFS_PIN_READ, 32'h0);
    rd(PRL_OFS_PIN_DIR, 32'h03FFFFFF);
    rd(PRL_OFS_MASK, 32'h0);
    done("reset");
    key(8'h40);
    key(8'h00);
    chk(32'(map_write_lock), 32'h1);
    wr(PRL_OFS_IRQ1_MAP, 32'h0);
    rd(PRL_OFS_IRQ1_MAP, 32'h1F00);
    do_reset();
    wr(PRL_OFS_IRQ1_MAP, 32'h0300);
    rd(PRL_OFS_IRQ1_MAP, 32'h0300);
    done("fuse");
    stop_test();
  end
endmodule
